// >>> hdl/rtps_pkg.sv
// package for the tag protocol state machine: map, fields, states, carriers
// Overview of operation
// - after startup, enter wait ready for requests
// - read identifier and inventory requests move tag to ready
// - matching select enters selected; select-only flag targets it
// - selected tag seeing other select goes quiet
// - silence request enters quiet; quiet obeys addressed only
// - invalid request leaves state unchanged
// - power-up broadcasts 128-bit data after listen window
// - broadcast data sent exactly as stored
// - request or switch in window selects reader-first
// - reader-first mode answers only state-valid requests
// - single slot: on mask match reply unmasked bits
// - zero mask: slot number is low identifier nibble
// - nonzero mask match: nibble above mask, counter cleared
// - each slot end-of-frame increments counter; equal replies
// - requests framed by start/end; fields sent lsb first
// - response: error flag, data, optional crc
// - flag bit 1 least significant, bit 5 most
// - protocol extension flag must be zero
// - inventory flag chooses meaning of bits 4, 5
// - response crc flag requests appended crc
// - inventory: bit 4 zero, bit 5 picks slots
// - addressed/select-only pair decodes which tags answer
// - responses outside broadcast open with start pattern
package rtps_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_UID_LO  = 8'h08;
  localparam logic [7:0] ADDR_UID_HI  = 8'h0c;
  localparam logic [7:0] ADDR_BDATA   = 8'h10;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
  localparam logic [47:0] UID_RESET   = 48'h0000_0000_0001;
  localparam int CTRL_BCAST_EN = 0;
  // status field positions
  localparam int ST_STATE_POS = 0;
  localparam int ST_RTF_POS   = 4;
  localparam int ST_INV_POS   = 5;
  localparam int ST_SCNT_POS  = 8;
  localparam int ST_SNUM_POS  = 12;
  // request field positions
  localparam int FLAG_PROTOCOL_EXTENSION_FLAG = 0;
  localparam int FLAG_INV  = 1;
  localparam int FLAG_RESPONSE_CRC_FLAG = 2;
  localparam int FLAG_B4   = 3;
  localparam int FLAG_B5   = 4;
  localparam int CMD_POS   = 5;
  localparam int PARAM_POS = 11;
  localparam int MASK_POS  = 17;
  localparam int HDR_BITS  = 11;
  localparam int UID_W     = 48;
  localparam int BDATA_W   = 128;
  localparam logic [5:0] MASK_MAX_16 = 6'd44;
  localparam logic [5:0] MASK_MAX_1  = 6'd48;
  // command codes
  localparam logic [5:0] CMD_INVENTORY  = 6'h00;
  localparam logic [5:0] CMD_SILENCE    = 6'h01;
  localparam logic [5:0] CMD_READ_UID   = 6'h02;
  localparam logic [5:0] CMD_SELECT     = 6'h18;
  localparam logic [5:0] CMD_BDATA_WR   = 6'h28;
  // timing
  localparam int CLK_MHZ         = 50;
  localparam int STARTUP_TIME_US = 2330;
  localparam int LISTEN_TIME_US  = 5000;
  localparam int STARTUP_CYCLES  = STARTUP_TIME_US * CLK_MHZ;
  localparam int LISTEN_CYCLES   = LISTEN_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_FIELD_OFF = 3'b000,
    ST_WAIT      = 3'b001,
    ST_READY     = 3'b010,
    ST_SELECTED  = 3'b011,
    ST_QUIET     = 3'b100,
    ST_BROADCAST = 3'b101
  } rtps_state_type;

  typedef struct packed {
    logic sof;
    logic bit_valid;
    logic bit_val;
    logic eof;
    logic crc_ok;
    logic switch_seen;
  } rtps_rx_in_type;

  typedef struct packed {
    logic valid;
    logic bit_val;
    logic sof;
    logic crc_req;
    logic broadcast;
  } rtps_tx_out_type;

  typedef struct packed {
    logic [7:0]         len;
    logic [BDATA_W-1:0] bits;
  } rtps_frame_type;
endpackage : rtps_pkg

// >>> hdl/rtps_mem.sv
// broadcast data store with registered read port
`timescale 1ns/1ps
module rtps_mem #(
  parameter int W = 32,
  parameter int D = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 we,
  input  wire logic [$clog2(D)-1:0] waddr,
  input  wire logic [W-1:0]         wdata,
  input  wire logic [$clog2(D)-1:0] raddr,
  output logic      [W-1:0]         rdata
);
  import rtps_pkg::*;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [W-1:0]        rdata;
  } rtps_mem_type;
  rtps_mem_type m_reg;
  rtps_mem_type m_next;

  // write, then registered read of unaltered contents
  always_comb begin
    m_next = m_reg;
    if (we) begin
      m_next.mem[waddr] = wdata;
    end
    m_next.rdata = m_reg.mem[raddr];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m_reg <= '0;
    end else begin
      m_reg <= m_next;
    end
  end

  assign rdata = m_reg.rdata;
endmodule : rtps_mem

// >>> hdl/rtps_rx.sv
// request frame collector between start and end of frame
`timescale 1ns/1ps
module rtps_rx (
  input  wire logic           clk,
  input  wire logic           rst,
  input  rtps_pkg::rtps_rx_in_type rx,
  output rtps_pkg::rtps_frame_type frame,
  output logic                frame_valid,
  output logic                slot_eof
);
  import rtps_pkg::*;
  typedef struct packed {
    rtps_frame_type fr;
    logic           in_frame;
    logic           valid;
    logic           slot_eof;
  } rtps_rx_type;
  rtps_rx_type r_reg;
  rtps_rx_type r_next;

  // bits land at rising index, so fields stay lsb first
  always_comb begin
    r_next = r_reg;
    r_next.valid = 1'b0;
    r_next.slot_eof = 1'b0;
    if (rx.sof) begin
      r_next.in_frame = 1'b1;
      r_next.fr = '0;
    end else if (rx.eof) begin
      if (r_reg.in_frame) begin
        r_next.valid = rx.crc_ok && (r_reg.fr.len >= 8'(HDR_BITS));
      end else begin
        r_next.slot_eof = 1'b1;
      end
      r_next.in_frame = 1'b0;
    end else if (rx.bit_valid && r_reg.in_frame && (r_reg.fr.len < 8'(BDATA_W))) begin
      r_next.fr.bits[r_reg.fr.len[6:0]] = rx.bit_val;
      r_next.fr.len = r_reg.fr.len + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign frame       = r_reg.fr;
  assign frame_valid = r_reg.valid;
  assign slot_eof    = r_reg.slot_eof;
endmodule : rtps_rx

// >>> hdl/rtps_top.sv
// tag protocol state machine with apb register access
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module rtps_top #(
  parameter int unsigned STARTUP_CYC = rtps_pkg::STARTUP_CYCLES,
  parameter int unsigned LISTEN_CYC  = rtps_pkg::LISTEN_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 field_on,
  input  rtps_pkg::rtps_rx_in_type  rx,
  input  wire logic                 tx_ready,
  output rtps_pkg::rtps_tx_out_type tx
);
  import rtps_pkg::*;

  typedef struct packed {
    rtps_state_type st;
    logic           reader_first_mode;
    logic [31:0]    tmr;
    logic [31:0]    ctrl;
    logic [47:0]    uid;
    logic [31:0]    prdata;
    logic           pslverr;
    logic           inv_on;
    logic [3:0]     slot_cnt;
    logic [3:0]     slot_num;
    logic [47:0]    inv_reply;
    logic [6:0]     inv_len;
    logic           busy;
    logic           sof;
    logic           crc;
    logic [63:0]    sh;
    logic [6:0]     left;
    logic [1:0]     bword;
  } rtps_top_type;

  rtps_top_type   r_reg;
  rtps_top_type   r_next;
  rtps_frame_type frame;
  logic           frame_valid;
  logic           slot_eof;
  logic [31:0]    mem_rdata;
  logic           mem_we;

  // mask of the n low identifier bits
  function automatic logic [47:0] low_mask(input logic [5:0] n);
    logic [47:0] m;
    m = '1;
    if (n < 6'd48) begin
      m = (48'h0000_0000_0001 << n) - 48'h0000_0000_0001;
    end
    return m;
  endfunction : low_mask

  // identifier equals received bits in n low positions
  function automatic logic id_match(input logic [47:0] id, input logic [47:0] v,
                                    input logic [5:0] n);
    return ((id ^ v) & low_mask(n)) == 48'h0000_0000_0000;
  endfunction : id_match

  rtps_rx u_rx (
    .clk         (clk),
    .rst         (rst),
    .rx          (rx),
    .frame       (frame),
    .frame_valid (frame_valid),
    .slot_eof    (slot_eof)
  );

  rtps_mem #(
    .W (32),
    .D (4)
  ) u_mem (
    .clk   (clk),
    .rst   (rst),
    .we    (mem_we),
    .waddr (paddr[3:2]),
    .wdata (pwdata),
    .raddr (r_reg.bword),
    .rdata (mem_rdata)
  );

  // broadcast store write strobe; no wait states
  assign mem_we = psel && penable && pwrite && (paddr[7:4] == ADDR_BDATA[7:4]);
  assign pready = 1'b1;

  // request decode, states, inventory, transmit
  always_comb begin
    logic [4:0]  f;
    logic [5:0]  cmd;
    logic [5:0]  n;
    logic [47:0] pid;
    logic [47:0] mval;
    logic        sel_only;
    logic        addressed;
    logic        allowed;
    logic        valid_req;
    logic        ready_like;
    logic        start_rsp;
    logic [63:0] rsp;
    logic [6:0]  rsp_len;
    logic [3:0]  nxt_cnt;
    f = frame.bits[FLAG_B5:FLAG_PROTOCOL_EXTENSION_FLAG];
    cmd = frame.bits[CMD_POS +: 6];
    n = frame.bits[PARAM_POS +: 6];
    pid = frame.bits[PARAM_POS +: UID_W];
    mval = frame.bits[MASK_POS +: UID_W];
    sel_only = f[FLAG_B4];
    addressed = f[FLAG_B5];
    valid_req = 1'b0;
    start_rsp = 1'b0;
    rsp = '0;
    rsp_len = '0;
    nxt_cnt = r_reg.slot_cnt + 4'h1;
    ready_like = (r_reg.st == ST_WAIT) || (r_reg.st == ST_READY);
    // which tags answer for this flag pair
    allowed = (addressed && !sel_only && (pid == r_reg.uid)) ||
              (!addressed && sel_only && (r_reg.st == ST_SELECTED)) ||
              (!addressed && !sel_only && ready_like);
    r_next = r_reg;
    r_next.sof = 1'b0;

    // apb setup captures read data and error into flops
    if (psel && !penable) begin
      r_next.pslverr = 1'b0;
      case (paddr)
        ADDR_STATUS: begin
          r_next.prdata = '0;
          r_next.prdata[ST_STATE_POS +: 3] = r_reg.st;
          r_next.prdata[ST_RTF_POS] = r_reg.reader_first_mode;
          r_next.prdata[ST_INV_POS] = r_reg.inv_on;
          r_next.prdata[ST_SCNT_POS +: 4] = r_reg.slot_cnt;
          r_next.prdata[ST_SNUM_POS +: 4] = r_reg.slot_num;
        end
        ADDR_CTRL:   r_next.prdata = r_reg.ctrl;
        ADDR_UID_LO: r_next.prdata = r_reg.uid[31:0];
        ADDR_UID_HI: r_next.prdata = {16'h0000, r_reg.uid[47:32]};
        default: begin
          r_next.prdata = '0;
          r_next.pslverr = (paddr[7:4] != ADDR_BDATA[7:4]) || (paddr[1:0] != 2'b00);
        end
      endcase
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        ADDR_CTRL:   r_next.ctrl = pwdata;
        ADDR_UID_LO: r_next.uid[31:0] = pwdata;
        ADDR_UID_HI: r_next.uid[47:32] = pwdata[15:0];
        default:     r_next.ctrl = r_reg.ctrl;
      endcase
    end

    // transmit shift: one bit per handshake, lsb first
    if (r_reg.busy && tx_ready) begin
      r_next.sh = {1'b0, r_reg.sh[63:1]};
      r_next.left = r_reg.left - 7'h01;
      if (r_reg.left == 7'h01) begin
        r_next.busy = 1'b0;
      end
    end

    case (r_reg.st)
      ST_FIELD_OFF: begin
        // startup count while field is present
        if (r_reg.tmr != 32'h0000_0000) begin
          r_next.tmr = r_reg.tmr - 32'h0000_0001;
        end else begin
          r_next.st = ST_WAIT;
          r_next.reader_first_mode = 1'b0;
          r_next.tmr = LISTEN_CYC;
        end
      end
      ST_BROADCAST: begin
        // load the next stored word once the last has gone
        if (!r_reg.busy) begin
          r_next.sh = {32'h0000_0000, mem_rdata};
          r_next.left = 7'd32;
          r_next.busy = 1'b1;
          r_next.bword = r_reg.bword + 2'b01;
        end
      end
      default: begin
        if (!r_reg.reader_first_mode && (r_reg.tmr != 32'h0000_0000)) begin
          r_next.tmr = r_reg.tmr - 32'h0000_0001;
          if (rx.switch_seen) begin
            r_next.reader_first_mode = 1'b1;
          end
        end else if (!r_reg.reader_first_mode) begin
          // window over, nothing heard: broadcast if enabled
          if (r_reg.ctrl[CTRL_BCAST_EN]) begin
            r_next.st = ST_BROADCAST;
            r_next.bword = 2'b00;
            r_next.busy = 1'b0;
          end else begin
            r_next.reader_first_mode = 1'b1;
          end
        end

        // sixteen-slot round stepping
        if (slot_eof && r_reg.inv_on) begin
          r_next.slot_cnt = nxt_cnt;
          if (nxt_cnt == r_reg.slot_num) begin
            start_rsp = 1'b1;
            rsp = {15'h0000, r_reg.inv_reply, 1'b0};
            rsp_len = r_reg.inv_len;
          end
        end

        // frames count only in the window or reader-first mode
        if (frame_valid && !f[FLAG_PROTOCOL_EXTENSION_FLAG] && (r_reg.reader_first_mode || (r_reg.tmr != 32'h0000_0000))) begin
          if (f[FLAG_INV]) begin
            // inventory: bit 4 zero, bit 5 slot count
            if ((cmd == CMD_INVENTORY) && !f[FLAG_B4] && ready_like &&
                (n <= (f[FLAG_B5] ? MASK_MAX_1 : MASK_MAX_16))) begin
              valid_req = 1'b1;
              r_next.st = ST_READY;
              r_next.inv_on = 1'b0;
              r_next.crc = f[FLAG_RESPONSE_CRC_FLAG];
              if (id_match(r_reg.uid, mval, n)) begin
                r_next.inv_reply = r_reg.uid >> n;
                r_next.inv_len = 7'd49 - {1'b0, n};
                if (f[FLAG_B5]) begin
                  start_rsp = 1'b1;
                  rsp = {15'h0000, r_reg.uid >> n, 1'b0};
                  rsp_len = 7'd49 - {1'b0, n};
                end else begin
                  r_next.inv_on = 1'b1;
                  r_next.slot_cnt = 4'h0;
                  r_next.slot_num = (n == 6'd0) ? r_reg.uid[3:0] :
                                    4'(r_reg.uid >> n);
                  if (((n == 6'd0) ? r_reg.uid[3:0] : 4'(r_reg.uid >> n)) == 4'h0) begin
                    start_rsp = 1'b1;
                    rsp = {15'h0000, r_reg.uid >> n, 1'b0};
                    rsp_len = 7'd49 - {1'b0, n};
                  end
                end
              end
            end
          end else begin
            case (cmd)
              CMD_SELECT: begin
                if (addressed && !sel_only && (pid == r_reg.uid)) begin
                  valid_req = 1'b1;
                  r_next.st = ST_SELECTED;
                end else if (addressed && !sel_only && (r_reg.st == ST_SELECTED)) begin
                  valid_req = 1'b1;
                  r_next.st = ST_QUIET;
                end
              end
              CMD_SILENCE: begin
                if (allowed && (addressed || sel_only) && (r_reg.st != ST_QUIET)) begin
                  valid_req = 1'b1;
                  r_next.st = ST_QUIET;
                  r_next.inv_on = 1'b0;
                end
              end
              CMD_READ_UID: begin
                if (allowed) begin
                  valid_req = 1'b1;
                  r_next.st = ST_READY;
                  start_rsp = 1'b1;
                  rsp = {15'h0000, r_reg.uid, 1'b0};
                  rsp_len = 7'd49;
                end
              end
              CMD_BDATA_WR: begin
                if (allowed) begin
                  valid_req = 1'b1;
                  start_rsp = 1'b1;
                  rsp = '0;
                  rsp_len = 7'd1;
                end
              end
              default: valid_req = 1'b0;
            endcase
            if (valid_req) begin
              r_next.crc = f[FLAG_RESPONSE_CRC_FLAG];
              r_next.inv_on = (cmd == CMD_SILENCE) ? 1'b0 : r_reg.inv_on;
            end
          end
          if (valid_req) begin
            r_next.reader_first_mode = 1'b1;
          end
        end

        // reply: error flag 0, then data; coder adds start
        if (start_rsp && !r_reg.busy) begin
          r_next.sh = rsp;
          r_next.left = rsp_len;
          r_next.busy = 1'b1;
          r_next.sof = 1'b1;
        end
      end
    endcase

    // field loss drops all context
    if (!field_on) begin
      r_next.st = ST_FIELD_OFF;
      r_next.reader_first_mode = 1'b0;
      r_next.tmr = STARTUP_CYC;
      r_next.inv_on = 1'b0;
      r_next.busy = 1'b0;
      r_next.sof = 1'b0;
      r_next.slot_cnt = 4'h0;
      r_next.bword = 2'b00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '{st: ST_FIELD_OFF, tmr: STARTUP_CYC, ctrl: CTRL_RESET, uid: UID_RESET,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata       = r_reg.prdata;
  assign pslverr      = r_reg.pslverr;
  assign tx.valid     = r_reg.busy;
  assign tx.bit_val   = r_reg.sh[0];
  assign tx.sof       = r_reg.sof;
  assign tx.crc_req   = r_reg.crc && (r_reg.st != ST_BROADCAST);
  assign tx.broadcast = (r_reg.st == ST_BROADCAST);
endmodule : rtps_top

// >>> tb/rtps_props.sv
// port checker for the tag protocol state machine
`timescale 1ns/1ps
module rtps_props #(
  parameter int unsigned STARTUP_CYC = 20,
  parameter int unsigned LISTEN_CYC  = 40
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic [7:0]           paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 field_on,
  input rtps_pkg::rtps_rx_in_type  rx,
  input wire logic                 tx_ready,
  input rtps_pkg::rtps_tx_out_type tx
);
  import rtps_pkg::*;
  logic [31:0] on_cnt_reg;
  // saturating count of field-on cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_cnt_reg <= 32'h0;
    end else begin
      on_cnt_reg <= !field_on ? 32'h0 : on_cnt_reg + {31'h0, on_cnt_reg != 32'hffff_ffff};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_pready_high: assert property (pready) else $error("pready low");
  a_sof_opens: assert property (tx.sof |-> tx.valid && !tx.broadcast)
    else $error("sof without valid");
  a_error_flag: assert property (tx.sof |-> !tx.bit_val)
    else $error("error flag set");
  a_bit_hold: assert property (tx.valid && !tx_ready && field_on ##1 field_on
    |-> tx.valid && $stable(tx.bit_val)) else $error("bit lost");
  a_reply_cause: assert property (tx.sof |-> $past(rx.eof, 2))
    else $error("reply without eof");
  a_off_silent: assert property (!field_on ##1 !field_on |-> !tx.sof && !tx.broadcast)
    else $error("activity without field");
  a_bcast_plain: assert property (tx.broadcast |-> !tx.crc_req && !tx.sof)
    else $error("framed broadcast");
  a_bcast_late: assert property (tx.broadcast |-> on_cnt_reg >= STARTUP_CYC + LISTEN_CYC)
    else $error("early broadcast");
  a_slverr_map: assert property (psel && penable
    |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00)) else $error("bad pslverr");
  c_reply: cover property (tx.sof);
  c_bcast: cover property (tx.broadcast);
  c_apb_err: cover property (psel && penable && pslverr);
endmodule : rtps_props

bind rtps_top rtps_props #(.STARTUP_CYC(STARTUP_CYC), .LISTEN_CYC(LISTEN_CYC)) i_props (
  .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .field_on(field_on),
  .rx(rx), .tx_ready(tx_ready), .tx(tx));

// >>> tb/rtps_rwu_model.sv
// reader_writer_unit model: powers the field, frames requests, takes replies
`timescale 1ns/1ps
module rtps_rwu_model (
  input  wire logic                 clk,
  input  rtps_pkg::rtps_tx_out_type tx,
  output logic                      field_on,
  output rtps_pkg::rtps_rx_in_type  rx,
  output logic                      tx_ready
);
  import rtps_pkg::*;
  logic         slow = 1'b0;
  logic         busy = 1'b0;
  logic         clr = 1'b0;
  logic [1:0]   ph = 2'b00;
  logic [127:0] rsp = '0;
  int           rsp_n = 0;
  logic         rsp_sof = 1'b0;
  logic         rsp_crc = 1'b0;
  initial begin
    field_on = 1'b0;
    rx = '0;
    tx_ready = 1'b1;
  end
  // take reply bits; slow stalls one cycle in four
  always @(posedge clk) begin
    ph <= ph + 2'd1;
    tx_ready <= !slow || ph != 2'd3;
    if (!busy) rx.bit_val <= !rx.bit_val; // idle line shows no stale bit
    if (clr) begin
      rsp <= '0;
      rsp_n <= 0;
      rsp_sof <= 1'b0;
    end else begin
      if (tx.valid && tx_ready && rsp_n < 128) begin
        rsp[rsp_n] <= tx.bit_val;
        rsp_n <= rsp_n + 1;
      end
      if (tx.sof) begin
        rsp_sof <= 1'b1;
        rsp_crc <= tx.crc_req;
      end
    end
  end
  task automatic power(input logic on);
    @(posedge clk);
    field_on <= on;
  endtask : power
  task automatic clear();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : clear
  // request framed by start and end, bits lsb first
  task automatic send(input logic [127:0] b, input int n, input logic ok);
    @(posedge clk);
    busy <= 1'b1;
    @(posedge clk);
    rx.sof <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx.sof <= 1'b0;
      rx.bit_valid <= 1'b1;
      rx.bit_val <= b[i];
    end
    @(posedge clk);
    rx.bit_valid <= 1'b0;
    rx.eof <= 1'b1;
    rx.crc_ok <= ok;
    @(posedge clk);
    rx.eof <= 1'b0;
    rx.crc_ok <= 1'b0;
    busy <= 1'b0;
  endtask : send
  // lone eof steps a slot; switch pattern is unframed
  task automatic strobe(input logic sw);
    @(posedge clk);
    if (sw) rx.switch_seen <= 1'b1;
    else rx.eof <= 1'b1;
    @(posedge clk);
    rx.switch_seen <= 1'b0;
    rx.eof <= 1'b0;
  endtask : strobe
endmodule : rtps_rwu_model

// >>> tb/tb_top.sv
// self-checking bench for the tag state machine
`timescale 1ns/1ps
module tb_top;
  import rtps_pkg::*;
  localparam int unsigned SU = 20;
  localparam int unsigned LW = 40;
  logic                      clk = 1'b0;
  logic                      rst = 1'b1;
  logic [7:0]                paddr;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      field_on;
  rtps_pkg::rtps_rx_in_type  rx;
  logic                      tx_ready;
  rtps_pkg::rtps_tx_out_type tx;
  int                        seed = 39646;
  int                        errors = 0;
  int                        checked = 0;
  logic [47:0]               uid;
  logic [127:0]              bd;
  logic [31:0]               q;
  logic                      e;
  always #10 clk = ~clk;
  rtps_top #(.STARTUP_CYC(SU), .LISTEN_CYC(LW)) i_dut (.clk(clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .field_on(field_on), .rx(rx), .tx_ready(tx_ready),
    .tx(tx));
  rtps_rwu_model i_rwu (.clk(clk), .tx(tx), .field_on(field_on), .rx(rx), .tx_ready(tx_ready));
  function automatic logic [127:0] req(input logic [4:0] f, input logic [5:0] c,
                                       input logic [63:0] p);
    return {53'h0, p, c, f};
  endfunction : req
  function automatic logic [127:0] low(input int n);
    return (128'h1 << n) - 128'h1;
  endfunction : low
  // error flag 0, then identifier bits above the mask
  function automatic logic [127:0] ans(input int n);
    return {79'h0, uid >> n, 1'b0};
  endfunction : ans
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
    apb(1'b0, a, 32'h0);
    check({e, q}, {ex, x});
  endtask : rd
  task automatic stat(input logic [2:0] s, input logic r);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({q[ST_RTF_POS], q[2:0]}, {r, s});
  endtask : stat
  // request, then reply length and content
  task automatic xfer(input logic [4:0] f, input logic [5:0] c, input int len, input logic ok,
                      input int n);
    i_rwu.clear();
    i_rwu.send(req(f, c, {16'h0, uid}), len, ok);
    repeat (150) @(posedge clk);
    check(i_rwu.rsp_n, n);
    check(i_rwu.rsp & low(n), ans(0) & low(n));
  endtask : xfer
  // inventory round; lone eof steps a slot
  task automatic round(input logic one, input int n, input logic [47:0] m, input int x);
    int k;
    i_rwu.clear();
    i_rwu.send(req(one ? 5'b10010 : 5'b00010, CMD_INVENTORY, {10'h0, m, 6'(n)}), 17 + n, 1);
    k = 0;
    repeat (120) @(posedge clk);
    while (!one && i_rwu.rsp_n == 0 && k < 16) begin
      i_rwu.strobe(1'b0);
      repeat (120) @(posedge clk);
      k++;
    end
    if (!one) check(k, x);
    check(i_rwu.rsp_n, x < 16 ? 49 - n : 0);
    check(i_rwu.rsp & low(49 - n), x < 16 ? ans(n) : 128'h0);
  endtask : round
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  // watchdog: many times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    uid = {16'($random(seed)), 32'($random(seed))};
    rd(ADDR_CTRL, CTRL_RESET, 1'b0);
    rd(ADDR_UID_LO, UID_RESET[31:0], 1'b0);
    apb(1'b1, ADDR_UID_LO, uid[31:0]);
    apb(1'b1, ADDR_UID_HI, {16'h0, uid[47:32]});
    rd(ADDR_UID_HI, {16'h0, uid[47:32]}, 1'b0);
    for (int k = 0; k < 4; k++) begin
      bd[32*k +: 32] = $random(seed);
      apb(1'b1, ADDR_BDATA + 8'(4 * k), bd[32*k +: 32]);
    end
    rd(ADDR_BDATA, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    rd(8'h02, 32'h0, 1'b1);
    $display("register test done");
    // silent power-up: stored data after the window
    i_rwu.power(1'b1);
    repeat (SU + 3) @(posedge clk);
    stat(ST_WAIT, 1'b0);
    i_rwu.clear();
    repeat (300) @(posedge clk);
    check(i_rwu.rsp, bd);
    stat(ST_BROADCAST, 1'b0);
    i_rwu.power(1'b0);
    repeat (3) @(posedge clk);
    stat(ST_FIELD_OFF, 1'b0);
    $display("broadcast test done");
    // switch pattern keeps the tag listening
    i_rwu.power(1'b1);
    repeat (SU + 5) @(posedge clk);
    i_rwu.strobe(1'b1);
    repeat (LW + 20) @(posedge clk);
    stat(ST_WAIT, 1'b1);
    i_rwu.slow = 1'b1;
    xfer(5'b00100, CMD_READ_UID, 11, 1'b1, 49);
    check({i_rwu.rsp_sof, i_rwu.rsp_crc}, 2'b11);
    xfer(5'b00000, CMD_READ_UID, 11, 1'b1, 49);
    check(i_rwu.rsp_crc, 1'b0);
    stat(ST_READY, 1'b1);
    xfer(5'b00001, CMD_READ_UID, 11, 1'b1, 0);
    xfer(5'b00100, CMD_READ_UID, 11, 1'b0, 0);
    stat(ST_READY, 1'b1);
    xfer(5'b10000, CMD_SELECT, 59, 1'b1, 0);
    stat(ST_SELECTED, 1'b1);
    uid[0] = !uid[0];
    xfer(5'b10000, CMD_SELECT, 59, 1'b1, 0);
    uid[0] = !uid[0];
    stat(ST_QUIET, 1'b1);
    xfer(5'b00100, CMD_READ_UID, 11, 1'b1, 0);
    xfer(5'b10000, CMD_BDATA_WR, 59, 1'b1, 1);
    stat(ST_QUIET, 1'b1);
    xfer(5'b10100, CMD_READ_UID, 59, 1'b1, 49);
    stat(ST_READY, 1'b1);
    $display("state test done");
    round(1'b1, 0, 48'h0, 0);
    round(1'b1, 48, uid, 0);
    for (int k = 0; k < 3; k++) begin
      e = 1'($random(seed));
      q = e ? 32'($unsigned($random(seed)) % 49) : 32'($unsigned($random(seed)) % 45);
      round(e, q, uid & 48'(low(q)), e ? 0 : (uid >> q) & 4'hf);
    end
    round(1'b1, 8, uid[7:0] ^ 8'h1, 16);
    round(1'b0, 0, 48'h0, uid[3:0]);
    round(1'b0, 44, uid & 48'(low(44)), uid[47:44]);
    round(1'b0, 4, uid[3:0] ^ 4'h8, 16);
    xfer(5'b10000, CMD_SILENCE, 59, 1'b1, 0);
    stat(ST_QUIET, 1'b1);
    i_rwu.power(1'b0);
    repeat (3) @(posedge clk);
    stat(ST_FIELD_OFF, 1'b0);
    $display("inventory test done");
    complete_run();
  end
endmodule : tb_top
